// *** logic/osc_clock_pkg.sv ***
// constants and types shared by the clock source switch files
package osc_clock_pkg;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h36; // request and engaged bits
  localparam logic [7:0] ADDR_CONTROL = 8'h37; // source select, pin option
  localparam logic [7:0] ADDR_TRIM    = 8'h38; // internal_clock_trim

  // field positions
  localparam int STAT_ENGAGED_BIT = 0;   // ext_clock_engaged, read only
  localparam int STAT_REQUEST_BIT = 1;   // ext_clock_request
  localparam int CTRL_SRC_LSB     = 0;   // clock_source_select[1:0]
  localparam int CTRL_PIN2_BIT    = 2;   // pin2_clock_out_enable

  // reset values
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [1:0] SRC_RESET  = 2'h0;

  // clock_source_select encodings
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXT_CLK  = 2'h1;
  localparam logic [1:0] SRC_EXT_RC   = 2'h2;
  localparam logic [1:0] SRC_CRYSTAL  = 2'h3;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CORE_CLK_HZ = 40_000_000;  // core_clk rate
  localparam int INT_OSC_HZ  = 4_000_000;   // nominal internal oscillator
  localparam int INT_HALF_CYCLES = CORE_CLK_HZ / (2 * INT_OSC_HZ);
  localparam int EXT_EDGES_TO_CONFIRM = 2;  // external rising edges
  // trim arithmetic: one core cycle is 512 units, one trim step adds
  // INT_HALF_CYCLES units to the half period (about 0.2 percent)
  localparam logic [12:0] ACC_STEP    = 13'h0200;
  localparam logic [12:0] TRIM_OFFSET = 13'h0180; // 512 - 128

  // switch sequencer states
  typedef enum logic [2:0] {
    SW_INTERNAL,
    SW_COUNT_EDGES,
    SW_ALIGN,
    SW_STOP_INTERNAL,
    SW_EXTERNAL
  } switch_state_e;

endpackage : osc_clock_pkg

// *** logic/clock_edge_sync.sv ***
// two-stage synchroniser with rising edge detect for a sampled clock
module clock_edge_sync (
  input  wire logic core_clk,    // system clock
  input  wire logic rst_n,       // async reset, active low
  input  wire logic clk_in,      // clock level to be sampled
  output logic      level_out,   // synchronised level
  output logic      rise_out     // one-cycle pulse on rising edge
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
  } sync_s;

  sync_s sync_ff;
  sync_s nxt_sync;

  // first stage feeds only the second
  always_comb begin
    nxt_sync        = sync_ff;
    nxt_sync.stage1 = clk_in;
    nxt_sync.stage2 = sync_ff.stage1;
    nxt_sync.prev   = sync_ff.stage2;
  end

  // register the state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign level_out = sync_ff.stage2;
  assign rise_out  = sync_ff.stage2 & ~sync_ff.prev;

endmodule : clock_edge_sync

// *** logic/osc_clock_source_switch.sv ***
// oscillator clock source selection, switchover and clock derivation
//
// What this block does
// - eight-bit trim moves internal period +127/-128 steps; larger is slower
// - reset loads trim register with midpoint 0x80
// - select 00 internal, 01 external clock, 10 RC, 11 crystal
// - external source makes pin one clock input; crystal drives pin two
// - after request, wait two external rising edges before switching
// - switch internal to external while both clocks are low; low phase lasts one cycle or more
// - set engaged status first, then stop internal oscillator
// - internal oscillator returns only on reset; no fallback
// - quad-rate output is the selected source clock itself
// - second output runs at half the quad-rate clock
// - pin two: crystal amp out, ext port I/O, else enable bit picks
// - integration unit enable starts or stops the internal oscillator and the quad-rate clock
// - wait mode leaves both output clocks running
// - stop mode halts the internal oscillator and both derived clocks
// - break state keeps both output clocks running
// - internal oscillator nominally 4.0 MHz, trimmed by trim register
// - reset selects the internal oscillator
// - reset forces the request bit low
// - engaged status is read only, 1 while external clock drives
//
// Decided for this implementation: the address-and-strobe port.
module osc_clock_source_switch #(
  parameter int HALF_CYCLES   = osc_clock_pkg::INT_HALF_CYCLES, // nominal
  parameter int CONFIRM_EDGES = osc_clock_pkg::EXT_EDGES_TO_CONFIRM
) (
  input  wire logic       core_clk,            // 40 MHz system clock
  input  wire logic       rst_n,               // async reset, active low
  input  wire logic [7:0] reg_addr,            // register address
  input  wire logic [7:0] reg_wdata,           // register write data
  input  wire logic       reg_wr,              // write strobe
  input  wire logic       reg_rd,              // read strobe
  output logic      [7:0] reg_rdata,           // read data, next cycle
  input  wire logic       osc_enable_from_integration, // source enable
  input  wire logic       clock_input_pin,     // external clock level
  input  wire logic       crystal_clock,       // crystal amplifier clock
  input  wire logic       rc_clock,            // rc oscillator clock
  input  wire logic       port_bit_four_out,   // port data for pin two
  input  wire logic       port_bit_four_oe,    // port drive for pin two
  output logic            clock_aux_pin_out,   // pin two output level
  output logic            clock_aux_pin_oe,    // pin two output enable
  output logic            clock_input_mode,    // pin one is a clock input
  output logic            quad_rate_clock,     // selected source clock
  output logic            double_rate_clock,   // half of quad rate
  output logic            internal_osc_clock,  // internal oscillator
  output logic            internal_osc_run,    // internal osc enabled
  output logic            ext_clock_engaged    // external drives clock
);
  import osc_clock_pkg::*;

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  if (HALF_CYCLES < 2 || HALF_CYCLES > 6) begin : g_bad_half
    $error("HALF_CYCLES must lie in 2..6");
  end
  if (CONFIRM_EDGES < 1 || CONFIRM_EDGES > 3) begin : g_bad_edges
    $error("CONFIRM_EDGES must lie in 1..3");
  end

  localparam logic [12:0] HALF_W  = 13'(HALF_CYCLES);
  localparam logic [1:0]  EDGES_W = 2'(CONFIRM_EDGES);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    trim;        // internal_clock_trim
    logic [1:0]    src_sel;     // clock_source_select
    logic          pin2_en;     // pin2_clock_out_enable
    logic          request;     // ext_clock_request
    logic          engaged;     // ext_clock_engaged
    logic          int_run;     // internal oscillator enabled
    logic [12:0]   acc;         // internal period accumulator
    logic          int_clk;     // internal oscillator level
    switch_state_e sw;          // switch sequencer
    logic [1:0]    edges;       // confirmed external edges
    logic          quad;        // quad-rate clock
    logic          dbl;         // double-rate clock
    logic          aux_out;     // pin two level
    logic          aux_oe;      // pin two drive
    logic          pin1_clk;    // pin one clock input mode
    logic [7:0]    rdata;       // read data
  } osc_s;

  localparam osc_s RST_STATE = '{
    trim:     TRIM_RESET,
    src_sel:  SRC_RESET,
    pin2_en:  1'b0,
    request:  1'b0,
    engaged:  1'b0,
    int_run:  1'b1,
    acc:      13'h0000,
    int_clk:  1'b0,
    sw:       SW_INTERNAL,
    edges:    2'h0,
    quad:     1'b0,
    dbl:      1'b0,
    aux_out:  1'b0,
    aux_oe:   1'b0,
    pin1_clk: 1'b0,
    rdata:    8'h00
  };

  osc_s st_ff;
  osc_s nxt_st;

  // -------------------------------------------------------------------
  // external source sampling
  // -------------------------------------------------------------------
  logic ext_src_clk;
  logic ext_level;
  logic ext_rise;

  // pick the external source clock by mode
  always_comb begin
    case (st_ff.src_sel)
      SRC_EXT_CLK: ext_src_clk = clock_input_pin;
      SRC_EXT_RC:  ext_src_clk = rc_clock;
      SRC_CRYSTAL: ext_src_clk = crystal_clock;
      default:     ext_src_clk = 1'b0;
    endcase
  end

  clock_edge_sync u_ext_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_in    (ext_src_clk),
    .level_out (ext_level),
    .rise_out  (ext_rise)
  );

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  logic [12:0] half_thr;
  logic [12:0] acc_sum;
  logic        sel_clk;
  logic        src_locked;

  always_comb begin
    nxt_st = st_ff;

    // larger trim gives a longer half period
    half_thr = HALF_W * (TRIM_OFFSET + {5'h00, st_ff.trim});
    acc_sum  = st_ff.acc + ACC_STEP;

    // source choice is frozen once a switch is under way
    src_locked = st_ff.request | st_ff.engaged;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_TRIM: begin
          nxt_st.trim = reg_wdata;
        end
        ADDR_STATUS: begin
          // engaged bit ignores writes
          nxt_st.request = reg_wdata[STAT_REQUEST_BIT];
        end
        ADDR_CONTROL: begin
          if (!src_locked) begin
            nxt_st.src_sel = reg_wdata[CTRL_SRC_LSB +: 2];
          end
          nxt_st.pin2_en = reg_wdata[CTRL_PIN2_BIT];
        end
        default: begin
        end
      endcase
    end

    // register reads, data one cycle later, unmapped reads zero
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TRIM: begin
          nxt_st.rdata = st_ff.trim;
        end
        ADDR_STATUS: begin
          nxt_st.rdata[STAT_REQUEST_BIT] = st_ff.request;
          nxt_st.rdata[STAT_ENGAGED_BIT] = st_ff.engaged;
        end
        ADDR_CONTROL: begin
          nxt_st.rdata[CTRL_SRC_LSB +: 2] = st_ff.src_sel;
          nxt_st.rdata[CTRL_PIN2_BIT]     = st_ff.pin2_en;
        end
        default: begin
        end
      endcase
    end

    // internal oscillator, frozen when disabled, held low when stopped
    if (st_ff.int_run && osc_enable_from_integration) begin
      if (acc_sum >= half_thr) begin
        nxt_st.acc     = acc_sum - half_thr;
        nxt_st.int_clk = ~st_ff.int_clk;
      end else begin
        nxt_st.acc = acc_sum;
      end
    end
    if (!st_ff.int_run) begin
      nxt_st.int_clk = 1'b0;
    end

    // switch sequencer
    case (st_ff.sw)
      SW_INTERNAL: begin
        nxt_st.edges = 2'h0;
        if (st_ff.request && st_ff.src_sel != SRC_INTERNAL) begin
          nxt_st.sw = SW_COUNT_EDGES;
        end
      end
      SW_COUNT_EDGES: begin
        // confirm the external clock is alive
        if (!st_ff.request) begin
          nxt_st.sw = SW_INTERNAL;
        end else if (ext_rise) begin
          nxt_st.edges = st_ff.edges + 2'h1;
          if (st_ff.edges == EDGES_W - 2'h1) begin
            nxt_st.sw = SW_ALIGN;
          end
        end
      end
      SW_ALIGN: begin
        // hand over only while both clocks are low
        if (!st_ff.request) begin
          nxt_st.sw = SW_INTERNAL;
        end else if (!st_ff.int_clk && !ext_level) begin
          nxt_st.engaged = 1'b1;
          nxt_st.sw      = SW_STOP_INTERNAL;
        end
      end
      SW_STOP_INTERNAL: begin
        // internal oscillator stops a cycle after engaged is set
        nxt_st.int_run = 1'b0;
        nxt_st.sw      = SW_EXTERNAL;
      end
      SW_EXTERNAL: begin
        // no way back except reset, even if the clock dies
        nxt_st.int_run = 1'b0;
      end
      default: begin
        nxt_st.sw = SW_INTERNAL;
      end
    endcase

    // quad-rate clock follows the active source; wait and break
    // have no effect here so both clocks keep running
    sel_clk = st_ff.engaged ? ext_level : st_ff.int_clk;
    if (osc_enable_from_integration) begin
      nxt_st.quad = sel_clk;
    end else begin
      nxt_st.quad = 1'b0;
    end

    // double-rate clock toggles on each quad-rate rising edge
    nxt_st.dbl = st_ff.dbl ^ (nxt_st.quad & ~st_ff.quad);

    // pin one becomes a clock input for any external choice
    nxt_st.pin1_clk = (st_ff.src_sel != SRC_INTERNAL);

    // pin two function by source
    case (st_ff.src_sel)
      SRC_CRYSTAL: begin
        nxt_st.aux_out = ~clock_input_pin;
        nxt_st.aux_oe  = 1'b1;
      end
      SRC_EXT_CLK: begin
        nxt_st.aux_out = port_bit_four_out;
        nxt_st.aux_oe  = port_bit_four_oe;
      end
      default: begin
        if (st_ff.pin2_en) begin
          nxt_st.aux_out = nxt_st.quad;
          nxt_st.aux_oe  = 1'b1;
        end else begin
          nxt_st.aux_out = port_bit_four_out;
          nxt_st.aux_oe  = port_bit_four_oe;
        end
      end
    endcase
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  // reset restores internal source, trim midpoint, no request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------
  // outputs, all from flip-flops
  // -------------------------------------------------------------------
  assign reg_rdata          = st_ff.rdata;
  assign clock_aux_pin_out  = st_ff.aux_out;
  assign clock_aux_pin_oe   = st_ff.aux_oe;
  assign clock_input_mode   = st_ff.pin1_clk;
  assign quad_rate_clock    = st_ff.quad;
  assign double_rate_clock  = st_ff.dbl;
  assign internal_osc_clock = st_ff.int_clk;
  assign internal_osc_run   = st_ff.int_run;
  assign ext_clock_engaged  = st_ff.engaged;

endmodule : osc_clock_source_switch

// *** sim/osc_clock_source_switch_assertions.sv ***
// checker for the clock source switch, bound to its top module
module osc_switch_checker
  import osc_clock_pkg::*;
#(
  parameter int HALF_CYCLES   = 5, // internal half period at midpoint
  parameter int CONFIRM_EDGES = 2  // external rises before switching
) (
  input wire logic       core_clk,                    // system clock
  input wire logic       rst_n,                       // async reset
  input wire logic [7:0] reg_addr,                    // register address
  input wire logic [7:0] reg_wdata,                   // write data
  input wire logic       reg_wr,                      // write strobe
  input wire logic       reg_rd,                      // read strobe
  input wire logic [7:0] reg_rdata,                   // read data
  input wire logic       osc_enable_from_integration, // source enable
  input wire logic       clock_input_pin,             // external level
  input wire logic       port_bit_four_oe,            // port drive
  input wire logic       clock_aux_pin_oe,            // pin two enable
  input wire logic       clock_input_mode,            // pin one input
  input wire logic       quad_rate_clock,             // source clock
  input wire logic       double_rate_clock,           // half rate
  input wire logic       internal_osc_run,            // internal runs
  input wire logic       ext_clock_engaged            // external engaged
);
  logic       req_ff;
  logic       pin_ff;
  logic [1:0] sel_ff;
  logic [7:0] trim_ff;
  logic [3:0] edge_ff;
  wire        rise = clock_input_pin && !pin_ff;
  wire        ctl_wr = reg_wr && reg_addr == ADDR_CONTROL;

  // shadow of request, select, trim and raw external rises
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff  <= 1'b0;
      pin_ff  <= 1'b0;
      sel_ff  <= SRC_RESET;
      trim_ff <= TRIM_RESET;
      edge_ff <= 4'h0;
    end else begin
      pin_ff <= clock_input_pin;
      if (reg_wr && reg_addr == ADDR_STATUS) req_ff <= reg_wdata[1];
      if (ctl_wr && !req_ff && !ext_clock_engaged) sel_ff <= reg_wdata[1:0];
      if (reg_wr && reg_addr == ADDR_TRIM) trim_ff <= reg_wdata;
      if (!req_ff) edge_ff <= 4'h0;
      else if (rise && edge_ff != 4'hF) edge_ff <= edge_ff + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence run_drop_s;
    internal_osc_run ##1 !internal_osc_run;
  endsequence
  property settled_p(logic ok);
    $stable(sel_ff) && sel_ff == $past(sel_ff, 2) |-> ok;
  endproperty

  engaged_hold_a: assert property (ext_clock_engaged |=> ext_clock_engaged)
    else $error("engaged status dropped");
  switch_order_a: assert property ($rose(ext_clock_engaged) |-> run_drop_s)
    else $error("internal oscillator not stopped after engage");
  run_hold_a: assert property (!internal_osc_run |=> !internal_osc_run)
    else $error("internal oscillator restarted");
  confirm_edges_a: assert property ($rose(ext_clock_engaged) |-> edge_ff >= CONFIRM_EDGES)
    else $error("switch before enough external rises");
  quad_stop_a: assert property (!osc_enable_from_integration |=> !quad_rate_clock)
    else $error("quad clock runs while disabled");
  double_follow_a: assert property ($rose(quad_rate_clock) |-> ##[0:1] $changed(double_rate_clock))
    else $error("half rate clock missed a quad rise");
  input_mode_a: assert property (settled_p(clock_input_mode == (sel_ff != SRC_INTERNAL)))
    else $error("pin one mode wrong for source");
  pin_crystal_a: assert property (settled_p(sel_ff != SRC_CRYSTAL || clock_aux_pin_oe))
    else $error("pin two not driven in crystal mode");
  pin_port_a: assert property (settled_p(sel_ff != SRC_EXT_CLK || clock_aux_pin_oe == $past(port_bit_four_oe)))
    else $error("pin two not port driven with external clock");
  trim_read_a: assert property (reg_rd && reg_addr == ADDR_TRIM |=> reg_rdata == trim_ff)
    else $error("trim read back wrong");
  status_read_a: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[0] == $past(ext_clock_engaged))
    else $error("engaged bit read back wrong");
endmodule : osc_switch_checker

bind osc_clock_source_switch osc_switch_checker #(
  .HALF_CYCLES(HALF_CYCLES), .CONFIRM_EDGES(CONFIRM_EDGES)
) osc_switch_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .osc_enable_from_integration(osc_enable_from_integration),
  .clock_input_pin(clock_input_pin), .port_bit_four_oe(port_bit_four_oe),
  .clock_aux_pin_oe(clock_aux_pin_oe), .clock_input_mode(clock_input_mode),
  .quad_rate_clock(quad_rate_clock), .double_rate_clock(double_rate_clock),
  .internal_osc_run(internal_osc_run), .ext_clock_engaged(ext_clock_engaged)
);

// *** sim/integration_unit_model.sv ***
// far side model: integration unit and the external clock source
module integration_unit_model #(
  parameter int EXT_HALF = 3 // core cycles per external half period
) (
  input  wire logic core_clk,                    // system clock
  input  wire logic ext_run,                     // let external swing
  input  wire logic stop_mode,                   // stop from bench
  input  wire logic double_rate_clock,           // half rate clock
  output logic      osc_enable_from_integration, // source enable
  output logic      ext_clock,                   // external level
  output logic      bus_clock                    // quarter of source
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  logic ext_ff = 1'b0; // external level, single driver
  logic bus_ff = 1'b0; // bus clock, single driver
  assign ext_clock = ext_ff;
  assign bus_clock = bus_ff;
  // wait and break keep the enable high, only stop drops it
  assign osc_enable_from_integration = !stop_mode;
  // external source, parked low while not running
  always @(posedge core_clk) begin
    cnt = ext_run && cnt < EXT_HALF - 1 ? cnt + 1 : 0;
    if (!ext_run) ext_ff <= 1'b0;
    else if (cnt == 0) ext_ff <= ~ext_ff;
  end
  // bus clock halves the half rate clock once more
  always @(posedge double_rate_clock) bus_ff <= ~bus_ff;
endmodule : integration_unit_model

// *** sim/osc_clock_source_switch_tb.sv ***
// self-checking bench for the clock source switch
module osc_clock_source_switch_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import osc_clock_pkg::*;
  localparam int HC = 5; // internal half period at midpoint trim
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       port_bit_four_out = 1'b1;
  logic       port_bit_four_oe = 1'b0;
  logic       ext_run = 1'b0;
  logic       stop_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rd_v;
  logic       en, ext, aux_out, aux_oe, in_mode, quad, dbl, iosc, run, eng;
  int         n_errors = 0;
  int         n_checks = 0;
  int         qc, dc, ic;

  always #12.5 core_clk = ~core_clk;

  osc_clock_source_switch #(.HALF_CYCLES(HC), .CONFIRM_EDGES(2))
    osc_clock_source_switch_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_enable_from_integration(en),
    .clock_input_pin(ext), .crystal_clock(ext), .rc_clock(ext),
    .port_bit_four_out(port_bit_four_out),
    .port_bit_four_oe(port_bit_four_oe), .clock_aux_pin_out(aux_out),
    .clock_aux_pin_oe(aux_oe), .clock_input_mode(in_mode),
    .quad_rate_clock(quad), .double_rate_clock(dbl),
    .internal_osc_clock(iosc), .internal_osc_run(run),
    .ext_clock_engaged(eng));
  integration_unit_model #(.EXT_HALF(3)) integration_unit_model_i (
    .core_clk(core_clk), .ext_run(ext_run), .stop_mode(stop_mode),
    .double_rate_clock(dbl), .osc_enable_from_integration(en),
    .ext_clock(ext), .bus_clock());

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic near(input int got, input int exp);
    check({7'h0, got >= exp - 1 && got <= exp + 1}, 8'h01);
  endtask : near
  task automatic end_sim;
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // one-cycle bus cycles; read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd
  // counts output toggles over n cycles
  task automatic count(input int n);
    logic q0, d0, i0;
    qc = 0;
    dc = 0;
    ic = 0;
    repeat (n) begin
      q0 = quad;
      d0 = dbl;
      i0 = iosc;
      @(posedge core_clk);
      #1;
      qc += int'(quad !== q0);
      dc += int'(dbl !== d0);
      ic += int'(iosc !== i0);
    end
  endtask : count

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_TRIM);
    check(rd_v, TRIM_RESET);
    rd(ADDR_STATUS);
    check(rd_v, 8'h00);
    rd(ADDR_CONTROL);
    check({6'h0, rd_v[1:0]}, {6'h0, SRC_INTERNAL});
    rd(8'h00);
    check(rd_v, 8'h00);
  endtask : t_reset
  task automatic t_trim;
    logic [7:0] tv[3] = '{8'h00, 8'h80, 8'hFF};
    foreach (tv[k]) begin
      wr(ADDR_TRIM, tv[k]);
      count(20);
      count(512);
      near(ic, 262144 / (HC * (384 + int'(tv[k]))));
      near(qc, ic);
      near(dc, qc / 2);
    end
  endtask : t_trim
  task automatic t_stop;
    stop_mode <= 1'b1;
    count(4);
    count(40);
    check(qc[7:0], 8'h00);
    check(dc[7:0], 8'h00);
    check(ic[7:0], 8'h00);
    stop_mode <= 1'b0;
    count(100);
    check({7'h0, qc > 10}, 8'h01);
  endtask : t_stop
  task automatic t_pin2;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(ADDR_CONTROL, {5'h0, p[0], s[1:0]});
        count(4);
        check({7'h0, in_mode}, {7'h0, s != 0});
        check({7'h0, aux_oe}, {7'h0, s == 3 || (s != 1 && p == 1)});
        if (s[0] || p == 0) check({7'h0, aux_out}, 8'h01);
      end
    end
  endtask : t_pin2
  task automatic t_switch;
    wr(ADDR_CONTROL, 8'h00); // back to internal before pre-drive
    port_bit_four_oe <= 1'b1; // pre-drive pin two high
    count(8);
    check({6'h0, aux_oe, aux_out}, 8'h03);
    wr(ADDR_CONTROL, {6'h0, SRC_CRYSTAL});
    port_bit_four_oe <= 1'b0;
    count(40); // settling delay
    wr(ADDR_STATUS, 8'h02);
    count(30);
    check({7'h0, eng}, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    check({7'h0, run}, 8'h01);
    wr(ADDR_STATUS, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    ext_run <= 1'b1;
    for (int i = 0; i < 300 && eng !== 1'b1; i++) count(1);
    if (eng !== 1'b1) n_errors++;
    if (eng !== 1'b1) end_sim();
    count(2);
    check({7'h0, run}, 8'h00);
    rd(ADDR_CONTROL);
    check({6'h0, rd_v[1:0]}, {6'h0, SRC_CRYSTAL});
    count(120);
    near(qc, 40);
    near(dc, qc / 2);
    ext_run <= 1'b0;
    count(40);
    check({6'h0, run, eng}, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS);
    check(rd_v, 8'h01);
    rst_n <= 1'b0;
    count(4);
    rst_n <= 1'b1;
    count(2);
    check({6'h0, run, eng}, 8'h02);
    rd(ADDR_TRIM);
    check(rd_v, TRIM_RESET);
  endtask : t_switch

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_trim();
    t_stop();
    t_pin2();
    t_switch();
    end_sim();
  end
endmodule : osc_clock_source_switch_tb
